/* File: rtl/mst_dac_lookup.sv */
// sine lookup: position index to one winding's dac code and polarity
`timescale 1ns/1ps
`default_nettype none

module mst_dac_lookup #(
  parameter logic [8:0][7:0] SineTbl = {8'hff, 8'hfa, 8'hec, 8'hd4, 8'hb4,
                                         8'h8e, 8'h62, 8'h32, 8'h00}
) (
  // position
  input  wire logic [4:0]        pos,
  // winding drive
  output mst_pkg::mst_wind_s     wind
);

  logic [2:0] step;
  logic [3:0] idx;

  assign step = pos[2:0];
  // odd quadrants run the table backwards
  assign idx  = pos[3] ? (4'h8 - {1'b0, step}) : {1'b0, step};

  assign wind.dacCode  = SineTbl[idx];
  assign wind.polarity = ~pos[4];

endmodule : mst_dac_lookup

`default_nettype wire

/* File: rtl/mst_defines.svh */
// constants for the microstep translator: offsets, fields, reset values, timing
`ifndef MST_DEFINES_SVH
`define MST_DEFINES_SVH

// register byte offsets
`define MST_OFS_CTRL     4'h0
`define MST_OFS_STATUS   4'h4
`define MST_OFS_OFFTIME  4'h8
`define MST_OFS_DAC      4'hc

// control fields
`define MST_CTRL_HOME    0
`define MST_CTRL_SWDIS   1
`define MST_CTRL_FLTCLR  2

// position and reset values
`define MST_POS_HOME     5'h04
`define MST_QUARTER      5'h08

// timing
`define MST_CLK_MHZ      20
`define MST_TOFF_US      30
`define MST_TBLANK_US    1
`define MST_TOFF_CYC     (`MST_TOFF_US * `MST_CLK_MHZ)
`define MST_TBLANK_CYC   (`MST_TBLANK_US * `MST_CLK_MHZ)
`define MST_FAST_NUM     5
`define MST_FAST_SHIFT   4

`endif

/* File: rtl/mst_pkg.sv */
// types shared by the microstep translator files
package mst_pkg;

  typedef enum logic [1:0] {
    MST_RES_FULL    = 2'b00,
    MST_RES_HALF    = 2'b01,
    MST_RES_QUARTER = 2'b10,
    MST_RES_EIGHTH  = 2'b11
  } mst_res_e;

  typedef enum logic [1:0] {
    MST_OFF_RES = 2'b00,
    MST_OFF_GND = 2'b01,
    MST_OFF_VDD = 2'b10
  } mst_offmode_e;

  typedef enum logic [2:0] {
    MST_PWM_ON   = 3'b001,
    MST_PWM_FAST = 3'b010,
    MST_PWM_SLOW = 3'b100
  } mst_pwm_state_e;

  typedef struct packed {
    logic       polarity;
    logic [7:0] dacCode;
  } mst_wind_s;

  typedef struct packed {
    logic drive;
    logic fastDecay;
    logic slowDecay;
  } mst_gate_s;

endpackage : mst_pkg

/* File: rtl/mst_pwm_bridge.sv */
// fixed off-time pwm regulator for one full bridge
`timescale 1ns/1ps
`default_nettype none
`include "mst_defines.svh"

module mst_pwm_bridge #(
  parameter int CntW = 16
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            nrst,
  // control
  input  wire logic            fetEn,
  input  wire logic            tripHit,
  input  wire logic            mixedMode,
  input  wire logic [CntW-1:0] offCycles,
  input  wire logic [CntW-1:0] fastCycles,
  // gate drive
  output mst_pkg::mst_gate_s   gate
);

  localparam logic [CntW-1:0] BlankCyc = CntW'(`MST_TBLANK_CYC);

  mst_pkg::mst_pwm_state_e state_r;
  logic [CntW-1:0]         cnt_r;
  mst_pkg::mst_gate_s      gate_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= mst_pkg::MST_PWM_ON;
      cnt_r   <= '0;
    end else if (!fetEn) begin
      state_r <= mst_pkg::MST_PWM_ON;
      cnt_r   <= BlankCyc - 1'b1;
    end else begin
      case (state_r)
        mst_pkg::MST_PWM_ON: begin
          // trip is blanked right after switching on
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (tripHit) begin
            cnt_r   <= offCycles - 1'b1; // [RULE17]
            state_r <= (mixedMode && fastCycles != '0) ?
                       mst_pkg::MST_PWM_FAST : mst_pkg::MST_PWM_SLOW; // [RULE14]
          end
        end
        mst_pkg::MST_PWM_FAST: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == offCycles - fastCycles) begin
            state_r <= mst_pkg::MST_PWM_SLOW; // [RULE14]
          end
        end
        default: begin
          if (cnt_r == '0) begin
            state_r <= mst_pkg::MST_PWM_ON;
            cnt_r   <= BlankCyc - 1'b1;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gate_r <= '0;
    end else begin
      gate_r.drive     <= fetEn && state_r == mst_pkg::MST_PWM_ON;
      gate_r.fastDecay <= fetEn && state_r == mst_pkg::MST_PWM_FAST;
      gate_r.slowDecay <= fetEn && state_r == mst_pkg::MST_PWM_SLOW;
    end
  end

  assign gate = gate_r;

endmodule : mst_pwm_bridge

`default_nettype wire

/* File: rtl/mst_translator.sv */
// microstep translator top: step sequencing, decay selection, pwm, register slave
// Behaviour
// [RULE1] controller holds step high and low at least 1 us each
// [RULE2] res_select 00 full, lo-only half, hi-only quarter, both eighth
// [RULE3] unconnected resolution pins read low through pull-downs
// [RULE4] reset loads home codes and polarities and mixed decay on both
// [RULE5] each step rising edge advances one increment, both windings
// [RULE6] translator drives each winding dac code and current direction
// [RULE7] increment size follows the resolution select inputs
// [RULE8] resolution change applies only at the next step rising edge
// [RULE9] a lowered dac level selects mixed decay for that bridge
// [RULE10] a raised or equal dac level selects slow decay
// [RULE11] home position is common to every resolution
// [RULE12] controller changes resolution only at a shared position
// [RULE13] thermal trip or overcurrent returns translator to home
// [RULE14] mixed decay: fast for 31.25% of off-time, then slow
// [RULE15] off-time pin grounded forces mixed decay always
// [RULE16] off-time pin grounded gives fixed 30 us off-time
// [RULE17] each bridge regulated by fixed off-time pwm
// [RULE18] reset input low holds home and turns all fets off
// [RULE19] step pulses ignored until reset input returns high
// [RULE20] position in eighth units, steps 8/4/2/1, wraps per cycle
// [RULE21] step edge detected on core clock, one advance per edge
// [RULE22] direction applies at next step rising edge
// [RULE23] disable input high turns fets off, translator keeps running
// [RULE24] off-time pin high: 30 us, auto mixed, full step slow
// [RULE25] controller waits 1 ms after sleep before first step
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mst_defines.svh"

module mst_translator #(
  parameter int CntW = 16
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // step and direction from the controller
  input  wire logic                 stepIn,
  input  wire logic                 dirIn,
  input  wire logic                 resSelLo,
  input  wire logic                 resSelHi,
  input  wire logic                 resetInN,
  input  wire logic                 disableIn,
  // off-time pin mode and protection
  input  wire logic [1:0]           offtimePin,
  input  wire logic                 thermalTrip,
  input  wire logic                 overCurrent,
  input  wire logic [1:0]           tripHit,
  // winding drive
  output mst_pkg::mst_wind_s [1:0]  windOut,
  output logic [1:0]                mixedDecay,
  output mst_pkg::mst_gate_s [1:0]  gateOut,
  // avalon-mm slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest
);

  localparam logic [CntW-1:0] ToffCyc = CntW'(`MST_TOFF_CYC);
  localparam logic [4:0]      PosHome = `MST_POS_HOME;

  // ---------------------------------------------------------------
  // bus slave state
  // ---------------------------------------------------------------

  logic                ack_r;
  logic                busReq;
  logic                wrTake;
  logic [31:0]         rdData_r;
  logic [31:0]         rdData_nxt;

  // software controls
  logic                swDisable_r;
  logic                homeReq_r;
  logic                fltClr;
  logic [CntW-1:0]     offReg_r;

  // ---------------------------------------------------------------
  // translator state
  // ---------------------------------------------------------------

  logic                stepPrev_r;
  logic                stepEdge;
  logic [4:0]          pos_r;
  logic [4:0]          inc;
  mst_pkg::mst_res_e   resSel;
  mst_pkg::mst_res_e   resAct_r;
  logic                dirAct_r;
  logic                stepDone_r;
  logic                goHome;
  logic                faultAny;
  logic [1:0]          fltSticky_r;
  logic [15:0]         stepCnt_r;

  // per-winding lookup results and decay
  mst_pkg::mst_wind_s [1:0] windNew;
  mst_pkg::mst_wind_s [1:0] wind_r;
  logic [1:0]          mixed_r;
  logic [1:0]          mixedEff;

  // pwm timing
  logic                fetEn;
  logic [CntW-1:0]     offCycles;
  logic [CntW+2:0]     fastProd;
  logic [CntW-1:0]     fastCycles;
  logic                offGnd;
  logic                offVdd;

  // ---------------------------------------------------------------
  // step input and resolution decode
  // ---------------------------------------------------------------

  // open pins read low, so an undriven select is full step
  assign resSel   = mst_pkg::mst_res_e'({resSelHi, resSelLo}); // [RULE2] [RULE3]

  assign faultAny = thermalTrip | overCurrent;

  // any of these sends the translator home and holds it there
  assign goHome   = !resetInN || faultAny || homeReq_r; // [RULE13] [RULE18]

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stepPrev_r <= 1'b0;
    end else begin
      stepPrev_r <= stepIn;
    end
  end

  // one advance per rising edge, none while held in reset
  assign stepEdge = stepIn && !stepPrev_r && !goHome; // [RULE21] [RULE19]

  // eighth units: full 8, half 4, quarter 2, eighth 1
  always_comb begin
    case (resSel)
      mst_pkg::MST_RES_FULL:    inc = 5'h08; // [RULE7] [RULE20]
      mst_pkg::MST_RES_HALF:    inc = 5'h04;
      mst_pkg::MST_RES_QUARTER: inc = 5'h02;
      default:                  inc = 5'h01;
    endcase
  end

  // ---------------------------------------------------------------
  // position counter
  // ---------------------------------------------------------------

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pos_r <= `MST_POS_HOME; // [RULE4]
    end else if (goHome) begin
      pos_r <= PosHome; // [RULE11] [RULE13] [RULE18]
    end else if (stepEdge) begin
      // five bits wrap once per electrical cycle
      pos_r <= dirIn ? pos_r + inc : pos_r - inc; // [RULE5] [RULE20] [RULE22]
    end
  end

  // resolution and direction are sampled only on the step edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resAct_r <= mst_pkg::MST_RES_FULL;
      dirAct_r <= 1'b0;
    end else if (stepEdge) begin
      resAct_r <= resSel;  // [RULE8]
      dirAct_r <= dirIn;   // [RULE22]
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stepDone_r <= 1'b0;
    end else begin
      stepDone_r <= stepEdge;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stepCnt_r <= '0;
    end else if (stepEdge) begin
      stepCnt_r <= stepCnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // winding lookup and decay selection
  // ---------------------------------------------------------------

  assign offGnd = offtimePin == mst_pkg::MST_OFF_GND;
  assign offVdd = offtimePin == mst_pkg::MST_OFF_VDD;

  genvar w;
  generate
    for (w = 0; w < 2; w++) begin : g_wind
      // winding 0 leads winding 1 by a quarter cycle
      mst_dac_lookup u_lookup (
        .pos  (pos_r + (w == 0 ? `MST_QUARTER : 5'h00)),
        .wind (windNew[w])
      );

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          wind_r[w] <= '0;
        end else begin
          wind_r[w] <= windNew[w]; // [RULE6]
        end
      end

      // the first cycle after a step compares new code with the old one
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          mixed_r[w] <= 1'b1; // [RULE4]
        end else if (goHome) begin
          mixed_r[w] <= 1'b1; // [RULE4]
        end else if (stepDone_r) begin
          if (resAct_r == mst_pkg::MST_RES_FULL) begin
            mixed_r[w] <= 1'b0; // [RULE24]
          end else if (windNew[w].dacCode < wind_r[w].dacCode) begin
            mixed_r[w] <= 1'b1; // [RULE9]
          end else begin
            mixed_r[w] <= 1'b0; // [RULE10]
          end
        end
      end

      // grounded off-time pin overrides the automatic choice
      assign mixedEff[w] = offGnd || mixed_r[w]; // [RULE15]

      mst_pwm_bridge #(
        .CntW (CntW)
      ) u_pwm (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .fetEn      (fetEn),
        .tripHit    (tripHit[w]),
        .mixedMode  (mixedEff[w]),
        .offCycles  (offCycles),
        .fastCycles (fastCycles),
        .gate       (gateOut[w])
      );
    end
  endgenerate

  assign windOut    = wind_r;
  assign mixedDecay = mixedEff;

  // ---------------------------------------------------------------
  // off-time and fet enable
  // ---------------------------------------------------------------

  // fixed 30 us when the pin is strapped, register value with a resistor
  assign offCycles  = (offGnd || offVdd) ? ToffCyc : offReg_r; // [RULE16] [RULE24]

  // 5/16 of the off-time is 31.25 percent
  assign fastProd   = (CntW+3)'(offCycles) * (CntW+3)'(`MST_FAST_NUM);
  assign fastCycles = fastProd[CntW+`MST_FAST_SHIFT-1:`MST_FAST_SHIFT]; // [RULE14]

  // translator keeps running while disableIn or the software disable holds the outputs off
  assign fetEn = resetInN && !disableIn && !swDisable_r && !faultAny; // [RULE18] [RULE23]

  // ---------------------------------------------------------------
  // avalon-mm slave, one wait cycle per access
  // ---------------------------------------------------------------

  assign busReq          = avs_read || avs_write;
  assign avs_waitrequest = busReq && !ack_r;
  assign wrTake          = avs_write && ack_r;
  assign fltClr          = wrTake && avs_address == `MST_OFS_CTRL &&
                           avs_byteenable[0] && avs_writedata[`MST_CTRL_FLTCLR];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= busReq && !ack_r;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      swDisable_r <= 1'b0;
      homeReq_r   <= 1'b0;
    end else if (wrTake && avs_address == `MST_OFS_CTRL && avs_byteenable[0]) begin
      swDisable_r <= avs_writedata[`MST_CTRL_SWDIS];
      homeReq_r   <= avs_writedata[`MST_CTRL_HOME];
    end else begin
      homeReq_r   <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      offReg_r <= ToffCyc;
    end else if (wrTake && avs_address == `MST_OFS_OFFTIME) begin
      if (avs_byteenable[0]) begin
        offReg_r[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        offReg_r[CntW-1:8] <= avs_writedata[CntW-1:8];
      end
    end
  end

  // a new fault in the clearing cycle keeps its flag
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fltSticky_r <= 2'b00;
    end else begin
      fltSticky_r <= (fltClr ? 2'b00 : fltSticky_r) | {overCurrent, thermalTrip};
    end
  end

  always_comb begin
    rdData_nxt = 32'h0000_0000;
    if (avs_address == `MST_OFS_CTRL) begin
      rdData_nxt[`MST_CTRL_SWDIS] = swDisable_r;
    end else if (avs_address == `MST_OFS_STATUS) begin
      rdData_nxt[4:0]   = pos_r;
      rdData_nxt[6:5]   = resAct_r;
      rdData_nxt[7]     = dirAct_r;
      rdData_nxt[9:8]   = mixedEff;
      rdData_nxt[11:10] = fltSticky_r;
      rdData_nxt[12]    = resetInN;
      rdData_nxt[13]    = fetEn;
      rdData_nxt[31:16] = stepCnt_r;
    end else if (avs_address == `MST_OFS_OFFTIME) begin
      rdData_nxt[CntW-1:0] = offReg_r;
    end else if (avs_address == `MST_OFS_DAC) begin
      rdData_nxt[7:0]   = wind_r[0].dacCode;
      rdData_nxt[8]     = wind_r[0].polarity;
      rdData_nxt[23:16] = wind_r[1].dacCode;
      rdData_nxt[24]    = wind_r[1].polarity;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdData_r <= '0;
    end else if (avs_read && !ack_r) begin
      rdData_r <= rdData_nxt;
    end
  end

  assign avs_readdata = rdData_r;

endmodule : mst_translator

`default_nettype wire

/* File: tb/mst_ctrl_model.sv */
// motion controller model: step pulses, direction and resolution pins
`timescale 1ns/1ps
`default_nettype none

module mst_ctrl_model #(
  parameter int PulseCyc = 20
) (
  // clock
  input  wire logic core_clk,
  // step link
  output logic      stepIn,
  output logic      dirIn,
  output wire logic resSelLo,
  output wire logic resSelHi
);
  logic [1:0] resDrv = 2'h0;
  logic       resOe = 1'b1;

  initial begin
    stepIn = 1'b0;
    dirIn = 1'b0;
  end

  // released pins are pulled low
  assign resSelLo = resOe ? resDrv[0] : 1'b0;
  assign resSelHi = resOe ? resDrv[1] : 1'b0;

  // pins settle one pulse width before the next step edge
  task automatic setPins(input logic [1:0] res, input logic dir, input logic oe);
    resDrv <= res;
    dirIn <= dir;
    resOe <= oe;
    repeat (PulseCyc) @(posedge core_clk);
  endtask : setPins

  task automatic steps(input int n);
    repeat (n) begin
      stepIn <= 1'b1;
      repeat (PulseCyc) @(posedge core_clk);
      stepIn <= 1'b0;
      repeat (PulseCyc) @(posedge core_clk);
    end
  endtask : steps
endmodule : mst_ctrl_model
`default_nettype wire

/* File: tb/mst_translator_asserts.sv */
// port checker for the microstep translator
`timescale 1ns/1ps
`default_nettype none

module mst_translator_asserts (
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     nrst,
  // controls
  input wire logic                     resetInN,
  input wire logic                     resSelLo,
  input wire logic                     resSelHi,
  input wire logic                     disableIn,
  input wire logic [1:0]               offtimePin,
  input wire logic                     thermalTrip,
  input wire logic                     overCurrent,
  // drive outputs
  input wire mst_pkg::mst_wind_s [1:0] windOut,
  input wire logic [1:0]               mixedDecay,
  input wire mst_pkg::mst_gate_s [1:0] gateOut
);
  logic [1:0] live_r;
  logic [9:0] fastCnt_r;
  logic [9:0] offCnt_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // skips the home load right after reset release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) live_r <= 2'h0;
    else if (live_r != 2'h3) live_r <= live_r + 2'h1;
  end

  // length of the running fast phase of bridge 0
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) fastCnt_r <= 10'h000;
    else fastCnt_r <= gateOut[0].fastDecay ? fastCnt_r + 10'h001 : 10'h000;
  end

  // length of the running off phase of bridge 0
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) offCnt_r <= 10'h000;
    else if (gateOut[0].fastDecay | gateOut[0].slowDecay) offCnt_r <= offCnt_r + 10'h001;
    else offCnt_r <= 10'h000;
  end

  AST_RESET_HOME: assert property (!resetInN [*3] |-> gateOut == '0 &&
    windOut[0] == 9'h1b4 && windOut[1] == 9'h1b4) else $error("reset pin low without home");
  AST_RESET_MIXED: assert property (!resetInN [*3] |-> mixedDecay == 2'h3)
    else $error("reset pin low without mixed decay");
  AST_DISABLE_OFF: assert property (disableIn [*3] |-> gateOut == '0)
    else $error("gates driven while disabled");
  AST_FAULT_HOME: assert property ((thermalTrip || overCurrent) [*3] |-> gateOut == '0 &&
    windOut[0] == 9'h1b4 && windOut[1] == 9'h1b4) else $error("fault without home");
  AST_GND_MIXED: assert property (offtimePin == 2'h1 |-> mixedDecay == 2'h3)
    else $error("grounded pin without mixed decay");
  AST_FALL_MIXED: assert property (live_r == 2'h3 && resetInN && !thermalTrip && !overCurrent
    && (resSelLo || resSelHi || offtimePin == 2'h1)
    && windOut[0].dacCode < $past(windOut[0].dacCode) |=> mixedDecay[0])
    else $error("falling level without mixed decay");
  AST_RISE_SLOW: assert property (live_r == 2'h3 && resetInN && offtimePin != 2'h1
    && !thermalTrip && !overCurrent
    && windOut[1].dacCode > $past(windOut[1].dacCode) |=> !mixedDecay[1])
    else $error("rising level without slow decay");
  AST_FAST_SHARE: assert property (offtimePin inside {2'h1, 2'h2} &&
    $fell(gateOut[0].fastDecay) && gateOut[0].slowDecay
    |-> fastCnt_r == 10'h0bb) else $error("fast decay share wrong");
  AST_OFF_FIXED: assert property ($rose(gateOut[0].drive) && $past(gateOut[0].slowDecay) &&
    offtimePin inside {2'h1, 2'h2} |-> offCnt_r == 10'h258) else $error("off time wrong");
endmodule : mst_translator_asserts

bind mst_translator mst_translator_asserts u_chk (.core_clk, .nrst, .resetInN, .resSelLo,
  .resSelHi, .disableIn,
  .offtimePin, .thermalTrip, .overCurrent, .windOut, .mixedDecay, .gateOut);
`default_nettype wire

/* File: tb/test_microstep_translator.sv */
// self-checking bench for the microstep translator
`timescale 1ns/1ps
`default_nettype none

module test_microstep_translator;
  typedef struct packed {
    logic [1:0] res;
    logic       dir;
    logic [2:0] n;
    logic [4:0] pos;
  } mst_row_s;

  logic                     core_clk = 1'b0;
  logic                     nrst = 1'b0;
  logic                     resetInN = 1'b1;
  logic                     disableIn = 1'b0;
  logic [1:0]               offtimePin = 2'h2;
  logic                     thermalTrip = 1'b0;
  logic                     overCurrent = 1'b0;
  logic [1:0]               tripHit = 2'h0;
  logic [3:0]               avs_address = 4'h0;
  logic                     avs_read = 1'b0;
  logic                     avs_write = 1'b0;
  logic [31:0]              avs_writedata = 32'h0;
  logic [3:0]               avs_byteenable = 4'hf;
  wire logic                stepIn, dirIn, resSelLo, resSelHi;
  mst_pkg::mst_wind_s [1:0] windOut;
  logic [1:0]               mixedDecay;
  mst_pkg::mst_gate_s [1:0] gateOut;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  logic [31:0]              d;
  int                       checks = 0;
  int                       n_fail = 0;
  int                       cyc = 0;
  // full steps only from positions shared with full resolution
  mst_row_s                 rows [0:6] = '{'{2'h0, 1'b1, 3'h1, 5'h0c}, '{2'h1, 1'b1, 3'h3, 5'h18},
    '{2'h2, 1'b0, 3'h2, 5'h14}, '{2'h3, 1'b1, 3'h5, 5'h19}, '{2'h3, 1'b0, 3'h5, 5'h14},
    '{2'h0, 1'b0, 3'h3, 5'h1c}, '{2'h1, 1'b1, 3'h2, 5'h04}};

  always #25 core_clk = ~core_clk;

  mst_translator u_dut (.core_clk, .nrst, .stepIn, .dirIn, .resSelLo, .resSelHi, .resetInN,
    .disableIn, .offtimePin, .thermalTrip, .overCurrent, .tripHit, .windOut, .mixedDecay,
    .gateOut, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest);
  mst_ctrl_model u_ctrl (.core_clk, .stepIn, .dirIn, .resSelLo, .resSelHi);

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    // request stands until an edge samples waitrequest low; data taken at that edge
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(32'({windOut, mixedDecay, gateOut}), 32'({9'h1b4, 9'h1b4, 2'h3, 6'h24}));
    bus(1'b0, 4'h4, 32'h0, d);
    chk(32'(d[4:0]), 32'h4);
    bus(1'b0, 4'h8, 32'h0, d);
    chk(d, 32'h258);
    bus(1'b1, 4'h8, 32'h100, d);
    bus(1'b0, 4'h8, 32'h0, d);
    chk(d, 32'h100);
    avs_byteenable <= 4'h1;
    bus(1'b1, 4'h8, 32'h0000_ff33, d);
    avs_byteenable <= 4'hf;
    bus(1'b0, 4'h8, 32'h0, d);
    chk(d, 32'h133);
    bus(1'b0, 4'h2, 32'h0, d);
    chk(d, 32'h0);
    // wake-up settling before the first step pulse
    repeat (20000) @(posedge core_clk);
    foreach (rows[i]) begin
      u_ctrl.setPins(rows[i].res, rows[i].dir, 1'b1);
      u_ctrl.steps(int'(rows[i].n));
      bus(1'b0, 4'h4, 32'h0, d);
      chk(32'(d[7:0]), 32'({rows[i].dir, rows[i].res, rows[i].pos}));
    end
    u_ctrl.setPins(2'h0, 1'b0, 1'b1);
    bus(1'b0, 4'h4, 32'h0, d);
    chk(32'(d[7:0]), 32'ha4);
    u_ctrl.setPins(2'h3, 1'b1, 1'b0);
    u_ctrl.steps(1);
    bus(1'b0, 4'h4, 32'h0, d);
    chk(32'(d[7:0]), 32'h8c);
    offtimePin <= 2'h1;
    u_ctrl.setPins(2'h3, 1'b1, 1'b1);
    u_ctrl.steps(3);
    chk(32'(mixedDecay), 32'h3);
    tripHit <= 2'h3;
    repeat (1400) @(posedge core_clk);
    offtimePin <= 2'h2;
    repeat (1400) @(posedge core_clk);
    offtimePin <= 2'h0;
    repeat (1400) @(posedge core_clk);
    disableIn <= 1'b1;
    u_ctrl.steps(1);
    chk(32'(gateOut), 32'h0);
    bus(1'b0, 4'h4, 32'h0, d);
    chk(32'(d[4:0]), 32'h10);
    disableIn <= 1'b0;
    resetInN <= 1'b0;
    u_ctrl.steps(2);
    chk(32'(gateOut), 32'h0);
    bus(1'b0, 4'h4, 32'h0, d);
    chk(32'(d[4:0]), 32'h4);
    resetInN <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      u_ctrl.steps(1);
      thermalTrip <= (k == 0);
      overCurrent <= (k == 1);
      repeat (4) @(posedge core_clk);
      bus(1'b0, 4'h4, 32'h0, d);
      chk(32'(d[4:0]), 32'h4);
      thermalTrip <= 1'b0;
      overCurrent <= 1'b0;
    end
    bus(1'b0, 4'h4, 32'h0, d);
    chk(32'(d[11:10]), 32'h3);
    bus(1'b1, 4'h0, 32'h4, d);
    bus(1'b0, 4'h4, 32'h0, d);
    chk(32'(d[11:10]), 32'h0);
    u_ctrl.steps(1);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(32'({windOut, mixedDecay}), 32'({9'h1b4, 9'h1b4, 2'h3}));
    report_and_stop();
  end
endmodule : test_microstep_translator
`default_nettype wire
